// ==== verilog/clock_ctrl_cfg.svh ====
// Configuration constants for the clock select and start-up reset block
// Overview of operation
// - The core clock enable feeds register file, flags and stack, and gating it stops the core.
// - Timers, serial ports and the external interrupt unit run on the peripheral clock enable, while some interrupt pins are still seen with it stopped.
// - Two-wire slave address matching stays enabled in every sleep mode.
// - The program memory clock follows the core clock.
// - The asynchronous timer domain can run from an external clock or 32 kHz crystal and keeps counting during sleep.
// - The converter has its own clock enable so core and peripheral clocks may stop during a conversion.
// - The USB clock comes from a PLL multiplying by 24 to 48MHz, and software must set the prescaler for a 2MHz PLL input.
// - Clock select 1111-1000 is low-power crystal, 0101-0100 low-frequency crystal, 0010 internal RC, 0000 external clock, others reserved.
// - Configuration bits read 1 unprogrammed and 0 programmed, and decoding uses that polarity.
// - The delivered configuration is clock select 1110, start-up 01 and divide-by-eight programmed.
// - After all other reset sources release, an internal reset is held for a watchdog-timed time-out chosen by the configuration.
// - The time-out is 0, 512 or 8192 watchdog oscillator cycles.
// - A ripple counter counts selected-oscillator cycles and holds reset until the start-up count is reached.
// - The oscillator start-up count ranges from 6 cycles for external clock up to 32K for a low-frequency crystal.
// - From reset both delays apply; on wake from power-save or power-down only the start-up count applies.
`ifndef CLOCK_CTRL_CFG_SVH
`define CLOCK_CTRL_CFG_SVH
`define ADR_CFG          4'h0
`define ADR_CTRL         4'h4
`define ADR_STATUS       4'h8
`define ADR_PLL          4'hc
`define CFG_RESET        32'h0000_001e
`define CTRL_RESET       6'h0f
`define PLL_RESET        8'h00
`define SEL_LSB          0
`define START_LSB        4
`define DIV8_BIT         6
`define CTRL_CORE_RUN    0
`define CTRL_IO_RUN      1
`define CTRL_ADC_RUN     2
`define CTRL_ASY_RUN     3
`define CTRL_DEEP        4
`define CTRL_PLL_EN      5
`define TOUT_SHORT       14'h0200
`define TOUT_LONG        14'h2000
`define SU_6             16'h0006
`define SU_258           16'h0102
`define SU_1K            16'h0400
`define SU_16K           16'h4000
`define SU_32K           16'h8000
`define PLL_MULT         6'h18
`define DIV8_LAST        3'h7
`endif

// ==== verilog/clock_ctrl_pkg.sv ====
// Types for the clock select and start-up reset block
package clock_ctrl_pkg;
    typedef enum logic [4:0] {
        SRC_LP_XTAL = 5'h01,
        SRC_LF_XTAL = 5'h02,
        SRC_RC      = 5'h04,
        SRC_EXT     = 5'h08,
        SRC_RSVD    = 5'h10
    } clk_src_t;
    typedef enum logic [3:0] {
        ST_TIMEOUT = 4'h1,
        ST_STARTUP = 4'h2,
        ST_RUN     = 4'h4,
        ST_SLEEP   = 4'h8
    } seq_state_t;
endpackage

// ==== verilog/startup_counter.sv ====
// Ripple-style start-up cycle counter on oscillator tick enables
`timescale 1ns/1ps
`include "clock_ctrl_cfg.svh"
module startup_counter (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        clear_i,
    input  wire logic        tick_i,
    input  wire logic [15:0] limit_i,
    output logic             done_o
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        done_q;
    logic        done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        if (clear_i) begin
            cnt_d  = 16'h0000;
            done_d = 1'b0;
        end else if (!done_q && cnt_q >= limit_i) begin
            done_d = 1'b1;
        end else if (tick_i && !done_q) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule

// ==== verilog/clock_ctrl.sv ====
// Clock source select, domain enables and internal start-up reset sequencer
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "clock_ctrl_cfg.svh"
module clock_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_reset_active_i,
    input  wire logic        wdt_osc_tick_i,
    input  wire logic        osc_tick_i,
    input  wire logic        wake_i,
    input  wire logic        async_timer_src_i,
    output logic             internal_reset_o,
    output logic             core_clock_en_o,
    output logic             program_memory_clock_en_o,
    output logic             peripheral_clock_en_o,
    output logic             ext_int_async_en_o,
    output logic             two_wire_match_en_o,
    output logic             async_timer_clock_en_o,
    output logic             converter_clock_en_o,
    output logic             usb_domain_clock_en_o,
    output logic             sys_clock_en_o,
    output logic [4:0]       clock_source_o
);
    // Configuration byte: select[3:0], start-up[5:4], divide-by-eight[6]
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [5:0]  ctrl_q;
    logic [5:0]  ctrl_d;
    logic [7:0]  pll_q;
    logic [7:0]  pll_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;

    logic [3:0]  clock_source_select;
    logic [1:0]  startup_time_select;
    logic        divide_by_eight_cfg;
    clock_ctrl_pkg::clk_src_t src;
    logic [13:0] power_up_timeout;
    logic [15:0] su_limit;

    assign clock_source_select = cfg_q[`SEL_LSB+3:`SEL_LSB];
    assign startup_time_select = cfg_q[`START_LSB+1:`START_LSB];
    assign divide_by_eight_cfg = cfg_q[`DIV8_BIT];

    // Programmed bits read 0: decoding compares on raw fuse values
    always_comb begin
        if (clock_source_select[3]) begin
            src = clock_ctrl_pkg::SRC_LP_XTAL;
        end else if (clock_source_select[3:1] == 3'h2) begin
            src = clock_ctrl_pkg::SRC_LF_XTAL;
        end else if (clock_source_select == 4'h2) begin
            src = clock_ctrl_pkg::SRC_RC;
        end else if (clock_source_select == 4'h0) begin
            src = clock_ctrl_pkg::SRC_EXT;
        end else begin
            src = clock_ctrl_pkg::SRC_RSVD;
        end
    end

    // Time-out and start-up counts per source
    always_comb begin
        power_up_timeout = 14'h0000;
        su_limit         = `SU_6;
        case (src)
            clock_ctrl_pkg::SRC_LP_XTAL: begin
                case ({clock_source_select[0], startup_time_select})
                    3'h0, 3'h3: power_up_timeout = `TOUT_SHORT;
                    3'h1, 3'h4: power_up_timeout = `TOUT_LONG;
                    3'h6:       power_up_timeout = `TOUT_SHORT;
                    3'h7:       power_up_timeout = `TOUT_LONG;
                    default:    power_up_timeout = 14'h0000;
                endcase
                if (!clock_source_select[0] && !startup_time_select[1]) begin
                    su_limit = `SU_258;
                end else if (!clock_source_select[0] || startup_time_select == 2'h0) begin
                    su_limit = `SU_1K;
                end else begin
                    su_limit = `SU_16K;
                end
            end
            clock_ctrl_pkg::SRC_LF_XTAL: begin
                // 32K needs all 16 counter bits
                su_limit = clock_source_select[0] ? `SU_32K : `SU_1K;
                power_up_timeout = startup_time_select[1] ? `TOUT_LONG :
                                   (startup_time_select[0] ? `TOUT_SHORT : 14'h0000);
            end
            clock_ctrl_pkg::SRC_RC, clock_ctrl_pkg::SRC_EXT: begin
                su_limit = `SU_6;
                power_up_timeout = startup_time_select[1] ? `TOUT_LONG :
                                   (startup_time_select[0] ? `TOUT_SHORT : 14'h0000);
            end
            default: begin
                su_limit         = `SU_6;
                power_up_timeout = 14'h0000;
            end
        endcase
    end

    // Sequencer
    clock_ctrl_pkg::seq_state_t st_q;
    clock_ctrl_pkg::seq_state_t st_d;
    logic [13:0] wdt_cnt_q;
    logic [13:0] wdt_cnt_d;
    logic        su_clear;
    logic        su_done;
    logic        deep_sleep;

    assign deep_sleep = ctrl_q[`CTRL_DEEP];

    always_comb begin
        st_d      = st_q;
        wdt_cnt_d = wdt_cnt_q;
        su_clear  = 1'b0;
        case (st_q)
            clock_ctrl_pkg::ST_TIMEOUT: begin
                su_clear = 1'b1;
                if (ext_reset_active_i) begin
                    wdt_cnt_d = 14'h0000;
                end else if (wdt_cnt_q >= power_up_timeout) begin
                    st_d = clock_ctrl_pkg::ST_STARTUP;
                end else if (wdt_osc_tick_i) begin
                    wdt_cnt_d = wdt_cnt_q + 14'h0001;
                end
            end
            clock_ctrl_pkg::ST_STARTUP: begin
                if (su_done) begin
                    st_d = clock_ctrl_pkg::ST_RUN;
                end
            end
            clock_ctrl_pkg::ST_RUN: begin
                if (deep_sleep) begin
                    st_d = clock_ctrl_pkg::ST_SLEEP;
                end
            end
            clock_ctrl_pkg::ST_SLEEP: begin
                su_clear = 1'b1;
                if (wake_i) begin
                    st_d = clock_ctrl_pkg::ST_STARTUP;
                end
            end
            default: begin
                st_d = clock_ctrl_pkg::ST_TIMEOUT;
            end
        endcase
        if (ext_reset_active_i) begin
            st_d      = clock_ctrl_pkg::ST_TIMEOUT;
            wdt_cnt_d = 14'h0000;
        end
    end

    startup_counter u_startup (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (su_clear),
        .tick_i  (osc_tick_i),
        .limit_i (su_limit),
        .done_o  (su_done)
    );

    // Divide-by-eight system clock enable
    logic [2:0] div_q;
    logic [2:0] div_d;
    always_comb begin
        div_d = div_q + 3'h1;
    end

    // Register file
    logic hit;
    assign hit = wb_cyc_i && wb_stb_i && !ack_q;

    always_comb begin
        cfg_d  = cfg_q;
        ctrl_d = ctrl_q;
        pll_d  = pll_q;
        ack_d  = hit;
        rdat_d = rdat_q;
        if (hit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `ADR_CFG:  cfg_d  = {25'h0, wb_dat_i[6:0]};
                `ADR_CTRL: ctrl_d = wb_dat_i[5:0];
                `ADR_PLL:  pll_d  = wb_dat_i[7:0];
                default:   cfg_d  = cfg_q;
            endcase
        end
        if (hit) begin
            case (wb_adr_i)
                `ADR_CFG:    rdat_d = cfg_q;
                `ADR_CTRL:   rdat_d = {26'h0, ctrl_q};
                `ADR_STATUS: rdat_d = {16'h0, st_q, clock_source_o, internal_reset_o,
                                       `PLL_MULT};
                `ADR_PLL:    rdat_d = {24'h0, pll_q};
                default:     rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // Domain enables
    logic running;
    logic sys_en;
    assign running = (st_q == clock_ctrl_pkg::ST_RUN);
    assign sys_en  = divide_by_eight_cfg ? 1'b1 : (div_q == `DIV8_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q     <= `CFG_RESET;
            ctrl_q    <= `CTRL_RESET;
            pll_q     <= `PLL_RESET;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0000_0000;
            st_q      <= clock_ctrl_pkg::ST_TIMEOUT;
            wdt_cnt_q <= 14'h0000;
            div_q     <= 3'h0;
            internal_reset_o          <= 1'b1;
            core_clock_en_o           <= 1'b0;
            program_memory_clock_en_o <= 1'b0;
            peripheral_clock_en_o     <= 1'b0;
            ext_int_async_en_o        <= 1'b1;
            two_wire_match_en_o       <= 1'b1;
            async_timer_clock_en_o    <= 1'b0;
            converter_clock_en_o      <= 1'b0;
            usb_domain_clock_en_o     <= 1'b0;
            sys_clock_en_o            <= 1'b0;
            clock_source_o            <= clock_ctrl_pkg::SRC_LP_XTAL;
        end else begin
            cfg_q     <= cfg_d;
            ctrl_q    <= ctrl_d;
            pll_q     <= pll_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
            st_q      <= st_d;
            wdt_cnt_q <= wdt_cnt_d;
            div_q     <= div_d;
            internal_reset_o          <= !running;
            core_clock_en_o           <= running && ctrl_q[`CTRL_CORE_RUN] && sys_en;
            program_memory_clock_en_o <= running && ctrl_q[`CTRL_CORE_RUN] && sys_en;
            peripheral_clock_en_o     <= running && ctrl_q[`CTRL_IO_RUN] && sys_en;
            ext_int_async_en_o        <= 1'b1;
            two_wire_match_en_o       <= 1'b1;
            // Async timer keeps its own source even asleep
            async_timer_clock_en_o    <= ctrl_q[`CTRL_ASY_RUN] && async_timer_src_i;
            converter_clock_en_o      <= running && ctrl_q[`CTRL_ADC_RUN] && sys_en;
            usb_domain_clock_en_o     <= running && ctrl_q[`CTRL_PLL_EN];
            sys_clock_en_o            <= running && sys_en;
            clock_source_o            <= src;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    a_release_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(internal_reset_o) |-> $past(st_q) == clock_ctrl_pkg::ST_RUN)
        else $error("reset released outside run");
    a_core_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[`CTRL_CORE_RUN] |=> !core_clock_en_o)
        else $error("core clock not gated");
    a_flash_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        program_memory_clock_en_o == core_clock_en_o)
        else $error("program memory clock differs");
    a_two_wire_always: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 two_wire_match_en_o && ext_int_async_en_o)
        else $error("address match disabled");
    a_timeout_first: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == clock_ctrl_pkg::ST_STARTUP && $past(st_q) == clock_ctrl_pkg::ST_TIMEOUT
        |-> $past(wdt_cnt_q) >= $past(power_up_timeout))
        else $error("start-up before time-out");
    a_wake_skips: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == clock_ctrl_pkg::ST_SLEEP && wake_i && !ext_reset_active_i
        |=> st_q == clock_ctrl_pkg::ST_STARTUP)
        else $error("wake did not skip time-out");
    a_ext_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        clock_source_select == 4'h0 |-> src == clock_ctrl_pkg::SRC_EXT && su_limit == `SU_6)
        else $error("external clock decode");
    a_adc_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        !running |=> !converter_clock_en_o && !peripheral_clock_en_o)
        else $error("domain on during reset");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    c_reach_run: cover property (@(posedge clk_i) disable iff (rst_i) $fell(internal_reset_o));
    c_sleep_wake: cover property (@(posedge clk_i) disable iff (rst_i)
        st_q == clock_ctrl_pkg::ST_SLEEP ##1 st_q == clock_ctrl_pkg::ST_STARTUP);
    c_cfg_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && wb_we_i && wb_adr_i == `ADR_CFG);
endmodule

// ==== tb/osc_source_model.sv ====
// Behavioural oscillator sources feeding the start-up sequencer
`timescale 1ns/1ps
module osc_source_model #(
    parameter int WDT_PERIOD = 1,
    parameter int OSC_PERIOD = 2
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      wdt_osc_tick_o,
    output logic      osc_tick_o
);
    int wdt_cnt_q = 0;
    int osc_cnt_q = 0;

    // Free-running phases; a stopped source gives no ticks at all
    always_ff @(posedge clk_i) begin
        wdt_cnt_q <= (wdt_cnt_q + 1) % WDT_PERIOD;
        osc_cnt_q <= (osc_cnt_q + 1) % OSC_PERIOD;
    end

    assign wdt_osc_tick_o = run_i && (wdt_cnt_q == WDT_PERIOD - 1);
    assign osc_tick_o     = run_i && (osc_cnt_q == OSC_PERIOD - 1);
endmodule

// ==== tb/test_clock_select_startup_reset.sv ====
// Self-checking bench for the clock select and start-up reset block
`timescale 1ns/1ps
`include "clock_ctrl_cfg.svh"
module test_clock_select_startup_reset;
    localparam int WP = 1;
    // Oscillator ticks every cycle so the 32K count fits the cycle budget
    localparam int OP = 1;
    localparam int SLACK = 12;
    localparam logic [7:0] CFG_T [13] = '{8'h41, 8'h43, 8'h46, 8'h47, 8'h6c, 8'h7c,
                                          8'h4d, 8'h6f, 8'h45, 8'h44, 8'h40, 8'h42, 8'h52};
    localparam logic [4:0] SRC_T [13] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h01, 5'h01,
                                          5'h01, 5'h01, 5'h02, 5'h02, 5'h08, 5'h04, 5'h04};
    localparam int TO_T [13] = '{-1, -1, -1, -1, 0, 512, 8192, 512, 0, 0, 0, 0, 512};
    localparam int SU_T [13] = '{0, 0, 0, 0, 1024, 1024, 1024, 16384, 32768, 1024, 6, 6, 6};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ext_reset_active_i = 1'b1;
    logic        wdt_osc_tick_i;
    logic        osc_tick_i;
    logic        wake_i = 1'b0;
    logic        async_timer_src_i = 1'b1;
    logic        internal_reset_o;
    logic        core_en, pm_en, per_en, ext_en, two_wire_en, asy_en, conv_en, usb_en, sys_en;
    logic [4:0]  clock_source_o;
    logic [7:0]  en_vec;
    int          miscompares = 0;
    int          check_count = 0;

    always #50 clk_i = ~clk_i;
    assign en_vec = {core_en, pm_en, per_en, ext_en, two_wire_en, asy_en, conv_en, usb_en};

    clock_ctrl i_clock_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_reset_active_i(ext_reset_active_i), .wdt_osc_tick_i(wdt_osc_tick_i),
        .osc_tick_i(osc_tick_i), .wake_i(wake_i), .async_timer_src_i(async_timer_src_i),
        .internal_reset_o(internal_reset_o), .core_clock_en_o(core_en),
        .program_memory_clock_en_o(pm_en), .peripheral_clock_en_o(per_en),
        .ext_int_async_en_o(ext_en), .two_wire_match_en_o(two_wire_en),
        .async_timer_clock_en_o(asy_en), .converter_clock_en_o(conv_en),
        .usb_domain_clock_en_o(usb_en), .sys_clock_en_o(sys_en),
        .clock_source_o(clock_source_o));

    osc_source_model #(.WDT_PERIOD(WP), .OSC_PERIOD(OP)) i_osc_source_model (
        .clk_i(clk_i), .run_i(1'b1), .wdt_osc_tick_o(wdt_osc_tick_i), .osc_tick_o(osc_tick_i));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_range(input int n, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, n, lo, hi);
        end
    endtask

    // Entered just after a rising edge; holds the request until ack is sampled
    task automatic wb_xfer(input logic we, input logic [3:0] sel, input logic [3:0] adr,
                           input logic [31:0] wdat, output logic [31:0] rdat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= adr;
        wb_dat_i <= wdat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
            conclude();
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] adr, input logic [31:0] d, input logic [3:0] sel = 4'hf);
        logic [31:0] r;
        wb_xfer(1'b1, sel, adr, d, r);
    endtask

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb_xfer(1'b0, 4'hf, adr, 32'h0, r);
        chk(r, exp);
    endtask

    // Start the release by an outside reset or by a wake, then time the internal reset
    task automatic boot(input int t_wdt, input int s_osc, input bit wake);
        int n;
        n = 0;
        if (wake) wake_i <= 1'b1;
        else ext_reset_active_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({31'h0, internal_reset_o}, 32'h1);
        wake_i <= 1'b0;
        ext_reset_active_i <= 1'b0;
        while (internal_reset_o !== 1'b0 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
        chk_range(n, t_wdt * WP + (s_osc - 1) * OP, t_wdt * WP + s_osc * OP + SLACK);
        if (n >= 40000) begin
            conclude();
        end
    endtask

    initial begin
        int c_core;
        int c_sys;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(`ADR_CFG, 32'h1e);
        rd_chk(`ADR_CTRL, 32'h0f);
        chk({27'h0, clock_source_o}, {27'h0, clock_ctrl_pkg::SRC_LP_XTAL});
        boot(8192, 258, 1'b0);
        c_core = 0;
        c_sys = 0;
        repeat (64) begin
            @(posedge clk_i);
            c_core += int'(core_en === 1'b1);
            c_sys += int'(sys_en === 1'b1);
        end
        chk_range(c_core, 8, 8);
        chk_range(c_sys, 8, 8);
        $display("test shipped configuration done");
        for (int i = 0; i < 13; i++) begin
            wr(`ADR_CFG, {24'h0, CFG_T[i]});
            repeat (3) @(posedge clk_i);
            chk({27'h0, clock_source_o}, {27'h0, SRC_T[i]});
            if (TO_T[i] >= 0) boot(TO_T[i], SU_T[i], 1'b0);
        end
        $display("test source select and start-up counts done");
        wr(4'h2, 32'h0);
        rd_chk(4'h2, 32'h0);
        wr(`ADR_CFG, 32'h40, 4'he);
        rd_chk(`ADR_CFG, 32'h52);
        wr(`ADR_PLL, 32'h05);
        rd_chk(`ADR_PLL, 32'h05);
        wr(`ADR_STATUS, 32'hffff_ffff);
        rd_chk(`ADR_STATUS, {16'h0, 4'h4, 5'h04, 1'b0, 6'h18});
        repeat (3) @(posedge clk_i);
        chk({24'h0, en_vec}, 32'hfe);
        wr(`ADR_CTRL, 32'h24);
        repeat (3) @(posedge clk_i);
        chk({24'h0, en_vec}, 32'h1b);
        async_timer_src_i <= 1'b0;
        wr(`ADR_CTRL, 32'h0b);
        repeat (3) @(posedge clk_i);
        chk({24'h0, en_vec}, 32'hf8);
        $display("test bus and domain enables done");
        async_timer_src_i <= 1'b1;
        wr(`ADR_CTRL, 32'h1f);
        repeat (3) @(posedge clk_i);
        chk({31'h0, internal_reset_o}, 32'h1);
        chk({26'h0, en_vec[7:2]}, 32'h07);
        wr(`ADR_CTRL, 32'h0f);
        boot(0, 6, 1'b1);
        $display("test sleep and wake done");
        conclude();
    end
endmodule
